/* File: rcs_pkg.sv */
// Constants, types and register layout of the regulator configuration slave
`default_nettype none
package rcs_pkg;
  // Register indices
  localparam logic [7:0] REG_FAULT = 8'h00;
  localparam logic [7:0] REG_LEVEL = 8'h01;
  localparam logic [7:0] REG_OPTION = 8'h02;
  localparam logic [7:0] REG_IDENT = 8'h03;
  localparam logic [7:0] REG_XFER = 8'h04;
  // Field positions
  localparam int FAULT_OC_BIT = 2;
  localparam int FAULT_OT_BIT = 1;
  localparam int FAULT_FB_BIT = 0;
  localparam int LEVEL_EN_BIT = 7;
  localparam int OPT_DELAY_BIT = 5;
  localparam int OPT_EDGE_BIT = 3;
  localparam int OPT_WINDOW_BIT = 2;
  localparam int OPT_OVP_BIT = 1;
  localparam int OPT_CCM_BIT = 0;
  localparam int XFER_GO_BIT = 5;
  localparam int XFER_DISC_BIT = 4;
  localparam int XFER_REG_BIT = 3;
  // Values after reset, and the option write mask
  localparam logic [2:0] FAULT_RST = 3'h0;
  localparam logic LEVEL_EN_RST = 1'b1;
  localparam logic [6:0] LEVEL_CODE_RST = 7'h40;
  localparam logic [7:0] OPT_RST = 8'h2F;
  localparam logic [7:0] OPT_MASK = 8'h2F;
  localparam logic XFER_DISC_RST = 1'b0;
  localparam logic [2:0] XFER_SLEW_RST = 3'h3;
  localparam logic PIN_IDLE = 1'b1;
  // Link framing
  localparam logic [4:0] ADDR_FIXED = 5'h1A;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_RX_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_TX_ACK = 3'h4,
    ST_SKIP = 3'h5
  } rcs_state_t;
endpackage
`default_nettype wire

/* File: rcs_pin_if.sv */
// Synchronised level and edge pulses of one link pin
`timescale 1ns/100ps
`default_nettype none
interface rcs_pin_if;
  logic level;
  logic rose;
  logic fell;
  modport drv (output level, output rose, output fell);
  modport use_side (input level, input rose, input fell);
endinterface
`default_nettype wire

/* File: rcs_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module rcs_pin_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Pin and result
  input wire logic pin_i,
  rcs_pin_if.drv pin
);
  import rcs_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rose;
    logic fell;
  } rcs_sync_t;
  rcs_sync_t q;
  rcs_sync_t next_q;
  always_comb begin
    next_q = q;
    next_q.s1 = pin_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.rose = 1'b0;
    next_q.fell = 1'b0;
    // Change accepted once stages two and three agree
    if (q.s2 == q.s3 && q.s3 != q.lvl) begin
      next_q.lvl = q.s3;
      next_q.rose = q.s3;
      next_q.fell = ~q.s3;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, lvl: PIN_IDLE, rose: 1'b0, fell: 1'b0};
    end else begin
      q <= next_q;
    end
  end
  assign pin.level = q.lvl;
  assign pin.rose = q.rose;
  assign pin.fell = q.fell;
endmodule
`default_nettype wire

/* File: rcs_config_slave.sv */
// Two-wire slave port and configuration registers of the regulator
`timescale 1ns/100ps
`default_nettype none
module rcs_config_slave #(
  parameter logic [1:0] ADDR_OPT = 2'h0,
  parameter logic [1:0] VOLT_OPT = 2'h1,
  // Arbitrary maker code
  parameter logic [3:0] MAKER_CODE = 4'h5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Converter events and status
  input wire logic overcurrent_evt_i,
  input wire logic overtemp_evt_i,
  input wire logic fb_undervolt_evt_i,
  input wire logic in_regulation_i,
  // Converter controls
  output logic regulator_enable_o,
  output logic [6:0] ref_code_o,
  output logic good_delay_disable_o,
  output logic switch_edge_rate_o,
  output logic good_window_both_sides_o,
  output logic input_overvolt_shutoff_o,
  output logic continuous_only_o,
  output logic transition_go_o,
  output logic discharge_o,
  output logic [2:0] ramp_rate_o
);
  import rcs_pkg::*;
  typedef struct packed {
    rcs_state_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [1:0] bno;
    logic rd;
    logic [7:0] ptr;
    logic mack;
    logic pend_v;
    logic [7:0] pend_reg;
    logic [7:0] pend_dat;
    logic sda_oe;
    logic [2:0] flags;
    logic en;
    logic [6:0] code;
    logic [7:0] opt;
    logic disc;
    logic [2:0] slew;
    logic go;
  } rcs_core_t;
  rcs_core_t q;
  rcs_core_t next_q;
  rcs_pin_if scl ();
  rcs_pin_if sda ();
  logic start_det;
  logic stop_det;
  rcs_pin_sync u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(scl_i),
    .pin(scl)
  );
  rcs_pin_sync u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sda_i),
    .pin(sda)
  );
  // Bus conditions
  assign start_det = sda.fell && scl.level;
  assign stop_det = sda.rose && scl.level;
  // Register read view
  function automatic logic [7:0] read_reg(input logic [7:0] idx, input rcs_core_t c, input logic live);
    logic [7:0] v;
    v = 8'h00;
    if (idx == REG_FAULT) begin
      v[2:0] = c.flags;
    end else if (idx == REG_LEVEL) begin
      v = {c.en, c.code};
    end else if (idx == REG_OPTION) begin
      v = c.opt & OPT_MASK;
    end else if (idx == REG_IDENT) begin
      v = {MAKER_CODE, ADDR_OPT, VOLT_OPT};
    end else if (idx == REG_XFER) begin
      v[XFER_DISC_BIT] = c.disc;
      v[XFER_REG_BIT] = live;
      v[2:0] = c.slew;
    end
    return v;
  endfunction
  always_comb begin
    logic [2:0] clr;
    logic [7:0] rv;
    clr = 3'h0;
    rv = read_reg(q.ptr, q, in_regulation_i);
    next_q = q;
    next_q.go = 1'b0;
    if (start_det) begin
      // Ordinary and repeated START alike drop any pending write
      next_q.st = ST_RX;
      next_q.bcnt = 4'h0;
      next_q.bno = 2'h0;
      next_q.pend_v = 1'b0;
      next_q.sda_oe = 1'b0;
    end else if (stop_det) begin
      next_q.st = ST_IDLE;
      next_q.sda_oe = 1'b0;
      next_q.pend_v = 1'b0;
      // Commit at STOP, regardless of enable state
      if (q.pend_v) begin
        if (q.pend_reg == REG_FAULT) begin
          clr = q.pend_dat[2:0];
        end else if (q.pend_reg == REG_LEVEL) begin
          next_q.en = q.pend_dat[LEVEL_EN_BIT];
          next_q.code = q.pend_dat[6:0];
        end else if (q.pend_reg == REG_OPTION) begin
          next_q.opt = q.pend_dat & OPT_MASK;
        end else if (q.pend_reg == REG_XFER) begin
          next_q.go = q.pend_dat[XFER_GO_BIT];
          next_q.disc = q.pend_dat[XFER_DISC_BIT];
          next_q.slew = q.pend_dat[2:0];
        end
      end
    end else begin
      case (q.st)
        ST_RX: begin
          if (scl.rose) begin
            next_q.sh = {q.sh[6:0], sda.level};
            next_q.bcnt = q.bcnt + 4'h1;
          end else if (scl.fell && q.bcnt == BYTE_BITS) begin
            next_q.st = ST_RX_ACK;
            next_q.sda_oe = 1'b1;
            case (q.bno)
              2'h0: begin
                if (q.sh[7:1] == {ADDR_FIXED, ADDR_OPT}) begin
                  next_q.rd = q.sh[0];
                end else begin
                  next_q.st = ST_SKIP;
                  next_q.sda_oe = 1'b0;
                end
              end
              2'h1: begin
                next_q.ptr = q.sh;
              end
              2'h2: begin
                next_q.pend_v = 1'b1;
                next_q.pend_reg = q.ptr;
                next_q.pend_dat = q.sh;
              end
              default: begin
                next_q.st = ST_SKIP;
                next_q.sda_oe = 1'b0;
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl.fell) begin
            next_q.bcnt = 4'h0;
            next_q.bno = q.bno + 2'h1;
            if (q.bno == 2'h0 && q.rd) begin
              next_q.st = ST_TX;
              next_q.sh = rv;
              next_q.sda_oe = ~rv[7];
            end else begin
              next_q.st = ST_RX;
              next_q.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl.fell) begin
            if (q.bcnt == TX_LAST) begin
              next_q.st = ST_TX_ACK;
              next_q.sda_oe = 1'b0;
              next_q.mack = 1'b0;
            end else begin
              next_q.bcnt = q.bcnt + 4'h1;
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe = ~q.sh[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl.rose) begin
            next_q.mack = ~sda.level;
          end else if (scl.fell) begin
            if (q.mack) begin
              next_q.ptr = q.ptr + 8'h01;
              next_q.st = ST_TX;
              next_q.bcnt = 4'h0;
              next_q.sh = read_reg(q.ptr + 8'h01, q, in_regulation_i);
              next_q.sda_oe = ~next_q.sh[7];
            end else begin
              next_q.st = ST_SKIP;
            end
          end
        end
        default: begin
          next_q.sda_oe = 1'b0;
        end
      endcase
    end
    // Event sets win over a clear in the same cycle
    next_q.flags = (q.flags & ~clr) | {overcurrent_evt_i, overtemp_evt_i, fb_undervolt_evt_i};
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.flags <= FAULT_RST;
      q.en <= LEVEL_EN_RST;
      q.code <= LEVEL_CODE_RST;
      q.opt <= OPT_RST;
      q.disc <= XFER_DISC_RST;
      q.slew <= XFER_SLEW_RST;
    end else begin
      q <= next_q;
    end
  end
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign regulator_enable_o = q.en;
  assign ref_code_o = q.code;
  assign good_delay_disable_o = q.opt[OPT_DELAY_BIT];
  assign switch_edge_rate_o = q.opt[OPT_EDGE_BIT];
  assign good_window_both_sides_o = q.opt[OPT_WINDOW_BIT];
  assign input_overvolt_shutoff_o = q.opt[OPT_OVP_BIT];
  assign continuous_only_o = q.opt[OPT_CCM_BIT];
  assign transition_go_o = q.go;
  assign discharge_o = q.disc;
  assign ramp_rate_o = q.slew;
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  start_restart_a: assert property (start_det |=> q.st == ST_RX && q.bcnt == 4'h0 && q.bno == 2'h0)
    else $error("start did not restart address reception");
  stop_free_a: assert property (stop_det |=> q.st == ST_IDLE && !sda_oe_o)
    else $error("stop did not free the bus");
  addr_match_a: assert property (q.st == ST_RX_ACK && q.bno == 2'h0 |-> q.sh[7:1] == {ADDR_FIXED, ADDR_OPT})
    else $error("acknowledged a foreign address");
  skip_release_a: assert property (q.st == ST_SKIP |-> !sda_oe_o)
    else $error("data line driven while off the bus");
  ninth_ack_a: assert property ($rose(sda_oe_o) && q.st == ST_RX_ACK |-> $past(q.bcnt) == BYTE_BITS)
    else $error("acknowledge not after eighth bit");
  sda_stable_a: assert property ($changed(sda_oe_o) && !$past(start_det) && !$past(stop_det) |-> !$past(scl.level))
    else $error("data line changed while clock high");
  level_commit_a: assert property ($changed(ref_code_o) || $changed(regulator_enable_o) |-> $past(stop_det))
    else $error("level register changed without stop");
  fault_sticky_a: assert property (overcurrent_evt_i |=> q.flags[FAULT_OC_BIT] [*2])
    else $error("overcurrent flag not held");
  go_pulse_a: assert property (transition_go_o |-> $past(stop_det) ##1 !transition_go_o)
    else $error("go pulse malformed");
  write_done_c: cover property (stop_det && q.pend_v);
  read_byte_c: cover property (q.st == ST_TX_ACK && scl.fell);
  addr_miss_c: cover property (q.st == ST_RX && scl.fell && q.bcnt == BYTE_BITS && q.bno == 2'h0 ##1 q.st == ST_SKIP);
  restart_c: cover property (start_det && q.st == ST_RX_ACK);
endmodule
`default_nettype wire

/* File: rcs_link_master.sv */
// Two-wire bus master model driving the link clock and data pins
`timescale 1ns/100ps
`default_nettype none
module rcs_link_master (
  // Clock
  input wire logic ref_clk_i,
  // Link pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Each link clock phase spans eight system clocks, more than the slave's response delay
  localparam int HALF = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    sda_o <= b;
    tick(HALF / 2);
    scl_o <= 1'b1;
    tick(HALF);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // Start, also used as repeated start
  task automatic start_cond();
    tick(HALF / 2);
    sda_o <= 1'b1;
    tick(HALF / 2);
    scl_o <= 1'b1;
    tick(HALF);
    sda_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(HALF / 2);
    sda_o <= 1'b0;
    tick(HALF / 2);
    scl_o <= 1'b1;
    tick(HALF);
    sda_o <= 1'b1;
    tick(HALF);
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic read_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the regulator configuration slave
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rcs_pkg::*;
  localparam logic [1:0] OPT = 2'h2;
  localparam logic [7:0] DEV_W = {ADDR_FIXED, OPT, 1'b0};
  localparam logic [7:0] ID = {4'h5, OPT, 2'h1};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic oc = 1'b0;
  logic ot = 1'b0;
  logic fb = 1'b0;
  logic in_reg = 1'b1;
  logic scl, m_sda, sda_out, sda_oe, en, dly, edg, win, ovp, ccm, go, disc, oe_prev;
  logic [6:0] code;
  logic [2:0] ramp;
  wire logic sda_line;
  int num_errors = 0;
  int checks_done = 0;
  int go_seen = 0;
  assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);
  always #25 clk = ~clk;
  rcs_link_master m (.ref_clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
  rcs_config_slave #(.ADDR_OPT(OPT)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .overcurrent_evt_i(oc), .overtemp_evt_i(ot),
    .fb_undervolt_evt_i(fb), .in_regulation_i(in_reg), .regulator_enable_o(en), .ref_code_o(code),
    .good_delay_disable_o(dly), .switch_edge_rate_o(edg), .good_window_both_sides_o(win),
    .input_overvolt_shutoff_o(ovp), .continuous_only_o(ccm), .transition_go_o(go),
    .discharge_o(disc), .ramp_rate_o(ramp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Counts: %0d mismatches in %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Slave output may only change while the link clock is low
  always @(posedge clk) begin
    if (go === 1'b1) go_seen++;
    if (rst_n === 1'b1 && scl === 1'b1) chk({7'h0, sda_oe}, {7'h0, oe_prev});
    oe_prev = sda_oe;
  end
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a0, a1, a2;
    m.start_cond();
    m.write_byte(DEV_W, a0);
    m.write_byte(idx, a1);
    m.write_byte(d, a2);
    m.stop_cond();
    chk({5'h0, a0, a1, a2}, 8'h07);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    m.start_cond();
    m.write_byte(DEV_W, a0);
    m.write_byte(idx, a1);
    m.start_cond();
    m.write_byte(DEV_W | 8'h01, a2);
    m.read_byte(1'b0, d);
    m.stop_cond();
    chk({6'h0, a0, a2}, 8'h03);
    chk(d, exp);
  endtask
  task automatic sc_reset();
    rd(8'h00, 8'h00);
    rd(8'h01, 8'hC0);
    rd(8'h02, 8'h2F);
    rd(8'h03, ID);
    rd(8'h04, 8'h0B);
    chk({en, code}, 8'hC0);
    chk({3'h0, dly, edg, win, ovp, ccm}, 8'h1F);
    chk({4'h0, disc, ramp}, 8'h03);
  endtask
  task automatic sc_wrong_addr();
    logic a0, a1;
    m.start_cond();
    m.write_byte({ADDR_FIXED, 2'h1, 1'b0}, a0);
    m.write_byte(8'h01, a1);
    m.stop_cond();
    chk({6'h0, a0, a1}, 8'h00);
    chk({en, code}, 8'hC0);
  endtask
  task automatic sc_write_go();
    in_reg <= 1'b0;
    wr(8'h01, 8'h15);
    chk({en, code}, 8'h15);
    go_seen = 0;
    wr(8'h04, 8'h37);
    chk(go_seen[7:0], 8'h01);
    chk({4'h0, disc, ramp}, 8'h0F);
    rd(8'h04, 8'h17);
    in_reg <= 1'b1;
  endtask
  task automatic sc_abort();
    logic a0, a1, a2;
    m.start_cond();
    m.write_byte(DEV_W, a0);
    m.write_byte(8'h02, a1);
    m.write_byte(8'h00, a2);
    rd(8'h02, 8'h2F);
    chk({3'h0, dly, edg, win, ovp, ccm}, 8'h1F);
  endtask
  task automatic sc_fault();
    @(posedge clk);
    oc <= 1'b1;
    fb <= 1'b1;
    @(posedge clk);
    oc <= 1'b0;
    fb <= 1'b0;
    rd(8'h00, 8'h05);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h01);
    ot <= 1'b1;
    @(posedge clk);
    ot <= 1'b0;
    rd(8'h00, 8'h03);
  endtask
  task automatic sc_reserved();
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h2F);
    wr(8'h03, 8'h00);
    rd(8'h03, ID);
    rd(8'h05, 8'h00);
  endtask
  task automatic sc_burst();
    logic a0, a1, a2;
    logic [7:0] d0, d1;
    m.start_cond();
    m.write_byte(DEV_W, a0);
    m.write_byte(8'h01, a1);
    m.start_cond();
    m.write_byte(DEV_W | 8'h01, a2);
    m.read_byte(1'b1, d0);
    m.read_byte(1'b0, d1);
    m.stop_cond();
    chk(d0, 8'h15);
    chk(d1, 8'h2F);
  endtask
  initial begin
    #2_000_000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    sc_reset();
    sc_wrong_addr();
    sc_write_go();
    sc_abort();
    sc_fault();
    sc_reserved();
    sc_burst();
    end_sim();
  end
endmodule
`default_nettype wire
